// File: core/sap_agent.sv
`timescale 1ns/1ps
`default_nettype none
module sap_agent (
  sap_if.agent bus,
  input wire logic issue,
  input wire sap_pkg::sap_addr_t issue_addr,
  input wire logic [sap_pkg::REQ_W-1:0] issue_req,
  input wire logic [1:0] issue_par_flip,
  output logic busy,
  output logic err_seen
);
  import sap_pkg::*;

  // ****************************************
  // Request drive
  // ****************************************
  typedef enum logic [1:0] {
    AG_IDLE = 2'b00, AG_ADDR = 2'b01, AG_TYPE = 2'b10
  } sap_ag_e;
  sap_ag_e st, next_st;
  sap_addr_t addr, next_addr;
  logic [REQ_W-1:0] req, next_req;
  logic err_s1, err_s2;
  logic next_err_seen;

  // Address while strobed, address lines all ones on the following cycle
  always_comb begin
    next_st = st;
    next_addr = addr;
    next_req = req;
    next_err_seen = err_seen;
    case (st)
      AG_IDLE: begin
        if (issue) begin
          next_st = AG_ADDR;
          next_addr = issue_addr;
          next_req = issue_req;
          next_err_seen = 1'b0;
        end
      end
      AG_ADDR: next_st = AG_TYPE;
      AG_TYPE: next_st = AG_IDLE;
      default: next_st = AG_IDLE;
    endcase
    if (!err_s2) begin
      next_err_seen = 1'b1;
    end
  end

  always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin  // R12
    if (!bus.rst_n) begin
      st <= AG_IDLE;
      addr <= ADDR_RST;
      req <= '1;
      err_s1 <= 1'b1;
      err_s2 <= 1'b1;
      err_seen <= 1'b0;
    end else begin
      st <= next_st;
      addr <= next_addr;
      req <= next_req;
      err_s1 <= bus.addr_parity_err_n;
      err_s2 <= err_s1;
      err_seen <= next_err_seen;
    end
  end

  // Registered pin drive; parity with the strobe, same cycle  R4
  always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      bus.ini_addr_o <= ADDR_RST;
      bus.ini_addr_oe_n <= 1'b1;
      bus.ini_strobe_o <= 1'b1;
      bus.ini_par_o <= PAR_RST;
      bus.ini_req_o <= '1;
      bus.ini_rpar_o <= 1'b1;
      bus.ini_err_o <= 1'b1;
      bus.ini_err_oe_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      busy <= (next_st != AG_IDLE);
      bus.ini_err_o <= 1'b1;
      bus.ini_err_oe_n <= 1'b1;
      bus.ini_addr_oe_n <= (next_st == AG_IDLE);
      bus.ini_strobe_o <= (next_st != AG_ADDR);  // R1
      bus.ini_addr_o <= (next_st == AG_TYPE) ? ADDR_RST : next_addr;  // R1
      bus.ini_par_o <= sap_parity(next_addr) ^ issue_par_flip;  // R2 R3
      bus.ini_req_o <= next_req;
      bus.ini_rpar_o <= ~^(~next_req);
    end
  end
endmodule : sap_agent
`default_nettype wire

// File: core/sap_device.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Address lines: address when strobed, else type; sap_agent drives all ones instead of the type
// (R2) Parity 1 covers 35..24, 0 covers 23..3
// (R3) Parity high for even count of lows
// (R4) Parity driven with strobe and address
// (R5) Sample address lines at reset release
// (R6) Mask address bit 20 when mask asserted
// (R7) Mask only asserted in real mode
// (R8) Mask valid by target ready of write
// (R9) Strobe starts checks of new transaction
// (R10) Observed parity error aborts if enabled
// (R11) Central agent handles error if disabled
// (R12) Everything on rising bus clock edge
// (R13) Drive parity error on mismatch if enabled
// (R14) Straps held until next reset
module sap_device (
  sap_if.device bus,
  input wire logic core_req,
  input wire sap_pkg::sap_addr_t core_addr,
  input wire logic [sap_pkg::REQ_W-1:0] core_type,
  input wire logic addr20_mask_in,
  output logic core_busy,
  output sap_pkg::sap_addr_t lookup_addr,
  output logic new_txn,
  output sap_pkg::sap_addr_t snoop_addr,
  output logic par_err,
  output logic txn_abort,
  output sap_pkg::sap_addr_t cfg
);
  import sap_pkg::*;

  // ****************************************
  // Input synchronisers and straps
  // ****************************************
  // Pins pass two flops before use, straps excepted; costs two cycles of latency
  sap_addr_t a_s1, a_s2;
  logic ads_s1, ads_s2, err_s1, err_s2, m_s1, m_s2;
  logic [1:0] ap_s1, ap_s2;
  logic cfg_done, next_cfg_done;
  sap_addr_t next_cfg;

  always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin  // R12
    if (!bus.rst_n) begin
      a_s1 <= ADDR_RST;
      a_s2 <= ADDR_RST;
      ads_s1 <= 1'b1;
      ads_s2 <= 1'b1;
      err_s1 <= 1'b1;
      err_s2 <= 1'b1;
      m_s1 <= 1'b0;
      m_s2 <= 1'b0;
    end else begin
      a_s1 <= bus.addr_bus;
      a_s2 <= a_s1;
      ads_s1 <= bus.addr_strobe_n;
      ads_s2 <= ads_s1;
      err_s1 <= bus.addr_parity_err_n;
      err_s2 <= err_s1;
      m_s1 <= addr20_mask_in;  // R8 asynchronous input
      m_s2 <= m_s1;
    end
  end

  always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      ap_s1 <= PAR_RST;
      ap_s2 <= PAR_RST;
    end else begin
      ap_s1 <= bus.addr_parity_n;
      ap_s2 <= ap_s1;
    end
  end

  // Straps taken once, first edge after release, then frozen
  always_comb begin
    next_cfg_done = 1'b1;
    next_cfg = cfg_done ? cfg : ~bus.addr_bus;  // R5 R14
  end

  // ****************************************
  // Request issue
  // ****************************************
  typedef enum logic [1:0] {
    DV_IDLE = 2'b00, DV_ADDR = 2'b01, DV_TYPE = 2'b10
  } sap_dv_e;
  sap_dv_e st, next_st;
  sap_addr_t addr, next_addr;
  logic [REQ_W-1:0] rtype, next_rtype;
  sap_addr_t masked;

  always_comb begin
    masked = core_addr;
    if (m_s2) begin
      masked[MASK_BIT-ADDR_LO] = 1'b0;  // R6 R7
    end
    next_st = st;
    next_addr = addr;
    next_rtype = rtype;
    case (st)
      DV_IDLE: begin
        if (core_req && cfg_done) begin
          next_st = DV_ADDR;
          next_addr = masked;  // R6
          next_rtype = core_type;
        end
      end
      DV_ADDR: next_st = DV_TYPE;
      DV_TYPE: next_st = DV_IDLE;
      default: next_st = DV_IDLE;
    endcase
  end

  always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      st <= DV_IDLE;
      addr <= '0;
      rtype <= '0;
      cfg_done <= 1'b0;
      cfg <= '0;
    end else begin
      st <= next_st;
      addr <= next_addr;
      rtype <= next_rtype;
      cfg_done <= next_cfg_done;
      cfg <= next_cfg;
    end
  end

  // Pins are active low: logical address inverted onto the wires
  always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      bus.dev_addr_o <= ADDR_RST;
      bus.dev_addr_oe_n <= 1'b1;
      bus.dev_strobe_o <= 1'b1;
      bus.dev_par_o <= PAR_RST;
      bus.dev_req_o <= '1;
      bus.dev_rpar_o <= 1'b1;
      core_busy <= 1'b0;
      lookup_addr <= '0;
    end else begin
      core_busy <= (next_st != DV_IDLE) || !cfg_done;
      lookup_addr <= masked;  // R6 cache lookup sees mask too
      bus.dev_addr_oe_n <= (next_st == DV_IDLE);
      bus.dev_strobe_o <= (next_st != DV_ADDR);  // R1
      bus.dev_addr_o <= (next_st == DV_TYPE)
        ? {{(ADDR_W-REQ_W){1'b1}}, ~next_rtype} : ~next_addr;  // R1
      bus.dev_par_o <= sap_parity(~next_addr);  // R2 R3 R4
      bus.dev_req_o <= ~next_rtype;
      bus.dev_rpar_o <= ~^next_rtype;  // R4
    end
  end

  // ****************************************
  // Observation and parity check
  // ****************************************
  logic mismatch;
  logic next_drive_err;

  // Strobe starts check; own drive is checked like any other
  always_comb begin
    mismatch = !ads_s2 && (sap_parity(a_s2) != ap_s2);  // R9 R2 R3
    next_drive_err = mismatch && cfg[CFG_APE_DRV];  // R13
  end

  always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      new_txn <= 1'b0;
      snoop_addr <= '0;
      par_err <= 1'b0;
      txn_abort <= 1'b0;
      bus.dev_err_o <= 1'b1;
      bus.dev_err_oe_n <= 1'b1;
    end else begin
      new_txn <= !ads_s2;  // R9
      if (!ads_s2) begin
        snoop_addr <= ~a_s2;  // R9 decode and snoop
      end
      par_err <= mismatch;
      // Without observation, the error is left to a central agent
      txn_abort <= !err_s2 && cfg[CFG_APE_OBS];  // R10 R11 R14
      bus.dev_err_o <= !next_drive_err;  // R13
      bus.dev_err_oe_n <= !next_drive_err;
    end
  end
endmodule : sap_device
`default_nettype wire

// File: pkg/sap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sap_if (
  input wire logic sys_clk,
  input wire logic rst_n
);
  import sap_pkg::*;
  // Active-low bus lines, resolved by the bench from the enables
  sap_addr_t addr_bus;
  logic addr_strobe_n;
  logic [1:0] addr_parity_n;
  logic [sap_pkg::REQ_W-1:0] request_type_n;
  logic request_parity_n;
  logic addr_parity_err_n;
  logic target_ready_n;
  // Initiator drives
  sap_addr_t ini_addr_o;
  logic ini_addr_oe_n;
  logic ini_strobe_o;
  logic [1:0] ini_par_o;
  logic [sap_pkg::REQ_W-1:0] ini_req_o;
  logic ini_rpar_o;
  // Device drives, then the initiator error drive
  sap_addr_t dev_addr_o;
  logic dev_addr_oe_n;
  logic dev_strobe_o;
  logic [1:0] dev_par_o;
  logic [sap_pkg::REQ_W-1:0] dev_req_o;
  logic dev_rpar_o;
  logic dev_err_o;
  logic dev_err_oe_n;
  logic ini_err_o;
  logic ini_err_oe_n;

  modport device (
    input sys_clk, rst_n, addr_bus, addr_strobe_n, addr_parity_n,
    input addr_parity_err_n, target_ready_n,
    output dev_addr_o, dev_addr_oe_n, dev_strobe_o, dev_par_o,
    output dev_req_o, dev_rpar_o, dev_err_o, dev_err_oe_n
  );
  modport agent (
    input sys_clk, rst_n, addr_bus, addr_strobe_n, addr_parity_n,
    input addr_parity_err_n,
    output ini_addr_o, ini_addr_oe_n, ini_strobe_o, ini_par_o,
    output ini_req_o, ini_rpar_o, ini_err_o, ini_err_oe_n
  );
endinterface : sap_if
`default_nettype wire

// File: pkg/sap_pkg.sv
package sap_pkg;
  // ****************************************
  // Address field layout
  // ****************************************
  localparam int ADDR_HI = 35;
  localparam int ADDR_LO = 3;
  localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
  localparam int PAR_HI_LSB = 24;  // Parity group 1 covers 35..24
  localparam int PAR_LO_MSB = 23;  // Parity group 0 covers 23..3
  localparam int MASK_BIT = 20;
  localparam int REQ_W = 5;
  localparam int CFG_APE_OBS = 4;  // Strap: parity error observation
  localparam int CFG_APE_DRV = 5;  // Strap: parity error driver
  localparam logic [ADDR_W-1:0] ADDR_RST = '1;
  localparam logic [1:0] PAR_RST = 2'h3;

  typedef logic [ADDR_W-1:0] sap_addr_t;

  // Parity on active-low lines: high when the count of lows is even
  function automatic logic [1:0] sap_parity(input sap_addr_t a_n);
    logic [1:0] p;
    p[1] = ~^(~a_n[ADDR_HI-ADDR_LO:PAR_HI_LSB-ADDR_LO]);
    p[0] = ~^(~a_n[PAR_LO_MSB-ADDR_LO:0]);
    return p;
  endfunction : sap_parity
endpackage : sap_pkg

// File: test/sap_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Pin checks
// ****
module sap_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sap_pkg::sap_addr_t addr_bus,
  input wire logic addr_strobe_n,
  input wire logic [1:0] addr_parity_n,
  input wire sap_pkg::sap_addr_t dev_addr_o,
  input wire logic dev_addr_oe_n,
  input wire logic dev_strobe_o,
  input wire logic [1:0] dev_par_o,
  input wire sap_pkg::sap_addr_t ini_addr_o,
  input wire logic ini_addr_oe_n,
  input wire logic ini_strobe_o,
  input wire logic dev_err_o,
  input wire logic dev_err_oe_n
);
  import sap_pkg::*;
  logic [1:0] en;
  logic got;
  logic bad;
  logic [1:0] next_en;
  logic next_got;
  // Own copy of the two parity error straps, taken at the first edge after reset
  always_comb begin
    next_en = en;
    next_got = 1'b1;
    if (!got) next_en = ~addr_bus[5:4];
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en <= 2'h0;
      got <= 1'b0;
    end else begin
      en <= next_en;
      got <= next_got;
    end
  end
  // Wire parity wrong on a strobed cycle
  assign bad = !addr_strobe_n && (addr_parity_n !=
    {~^(~addr_bus[32:21]), ~^(~addr_bus[20:0])});
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence dev_adr_s;
    !dev_strobe_o && !dev_addr_oe_n;
  endsequence
  sequence dev_typ_s;
    dev_strobe_o && !dev_addr_oe_n && (&dev_addr_o[32:5]);
  endsequence
  a_dev_frame: assert property (dev_adr_s |=> dev_typ_s ##1 dev_addr_oe_n)
    else $error("device frame wrong");
  a_ini_frame: assert property (!ini_strobe_o && !ini_addr_oe_n |=>
    ini_strobe_o && !ini_addr_oe_n && (&ini_addr_o) ##1 ini_addr_oe_n)
    else $error("agent frame wrong");
  a_par_hi: assert property (dev_adr_s |->
    dev_par_o[1] == ~^(~dev_addr_o[32:21])) else $error("high parity");
  a_par_lo: assert property (dev_adr_s |->
    dev_par_o[0] == ~^(~dev_addr_o[20:0])) else $error("low parity");
  a_wire_par: assert property (!addr_strobe_n && !dev_addr_oe_n |-> !bad)
    else $error("wire parity");
  a_err_drive: assert property (bad && en[1] |-> ##3
    !dev_err_oe_n && !dev_err_o) else $error("error not driven");
  a_err_quiet: assert property (!en[1] |-> dev_err_oe_n)
    else $error("error driven while off");
  a_err_cause: assert property ($fell(dev_err_oe_n) |-> $past(bad, 3))
    else $error("error without cause");
endmodule : sap_checker
`default_nettype wire

// File: test/sysbus_address_phase_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module sysbus_address_phase_tb_top;
  import sap_pkg::*;
  logic sys_clk;
  logic rst_n = 0;
  logic core_req = 0;
  sap_addr_t core_addr = '0;
  logic [4:0] core_type = 0;
  logic addr20_mask_in = 0;
  logic issue = 0;
  sap_addr_t issue_addr = '1;
  logic [4:0] issue_req = '1;
  logic [1:0] issue_par_flip = 0;
  logic strap_on = 1;
  sap_addr_t strap_n = '1;
  logic addr_parity_err_n_n = 1;
  logic [1:0] en_m;
  logic core_busy, new_txn, par_err, txn_abort, busy, err_seen;
  sap_addr_t lookup_addr, snoop_addr, cfg;
  sap_addr_t q[$];
  int n_errors = 0;
  int checked = 0;
  sap_if bus (.sys_clk(sys_clk), .rst_n(rst_n));
  // Open-drain style wires: low wins, released lines pulled high
  assign bus.addr_bus = (bus.dev_addr_oe_n ? '1 : bus.dev_addr_o) &
    (bus.ini_addr_oe_n ? '1 : bus.ini_addr_o) & (strap_on ? strap_n : '1);
  assign bus.addr_strobe_n = (bus.dev_addr_oe_n | bus.dev_strobe_o) &
    (bus.ini_addr_oe_n | bus.ini_strobe_o);
  assign bus.addr_parity_n = (bus.dev_addr_oe_n ? 2'h3 : bus.dev_par_o) &
    (bus.ini_addr_oe_n ? 2'h3 : bus.ini_par_o);
  assign bus.request_type_n = (bus.dev_addr_oe_n ? 5'h1F : bus.dev_req_o) &
    (bus.ini_addr_oe_n ? 5'h1F : bus.ini_req_o);
  assign bus.request_parity_n = (bus.dev_addr_oe_n | bus.dev_rpar_o) &
    (bus.ini_addr_oe_n | bus.ini_rpar_o);
  assign bus.addr_parity_err_n = (bus.dev_err_oe_n | bus.dev_err_o) &
    (bus.ini_err_oe_n | bus.ini_err_o) & addr_parity_err_n_n;
  assign bus.target_ready_n = 1'b1;
  sap_device sap_device_i (.bus(bus.device), .core_req(core_req),
    .core_addr(core_addr), .core_type(core_type),
    .addr20_mask_in(addr20_mask_in), .core_busy(core_busy),
    .lookup_addr(lookup_addr), .new_txn(new_txn), .snoop_addr(snoop_addr),
    .par_err(par_err), .txn_abort(txn_abort), .cfg(cfg));
  sap_agent sap_agent_i (.bus(bus.agent), .issue(issue),
    .issue_addr(issue_addr), .issue_req(issue_req),
    .issue_par_flip(issue_par_flip), .busy(busy), .err_seen(err_seen));
  sap_checker sap_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .addr_bus(bus.addr_bus), .addr_strobe_n(bus.addr_strobe_n),
    .addr_parity_n(bus.addr_parity_n), .dev_addr_o(bus.dev_addr_o),
    .dev_addr_oe_n(bus.dev_addr_oe_n), .dev_strobe_o(bus.dev_strobe_o),
    .dev_par_o(bus.dev_par_o), .ini_addr_o(bus.ini_addr_o),
    .ini_addr_oe_n(bus.ini_addr_oe_n), .ini_strobe_o(bus.ini_strobe_o),
    .dev_err_o(bus.dev_err_o), .dev_err_oe_n(bus.dev_err_oe_n));
  // Bus clock, 8 ns
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // Bounded wait for a strobed cycle, sampled mid-cycle
  task automatic wait_st();
    int i;
    i = 0;
    @(negedge sys_clk);
    while (bus.addr_strobe_n !== 1'b0) begin
      i++;
      if (i > 20) begin
        chk(33'h0, 33'h1);
        final_report();
      end
      @(negedge sys_clk);
    end
  endtask : wait_st
  // Straps on the lines while reset releases
  task automatic do_reset(input logic [1:0] en);
    sap_addr_t s;
    s = sap_addr_t'({$urandom, $urandom});
    s[CFG_APE_DRV] = ~en[1];
    s[CFG_APE_OBS] = ~en[0];
    @(posedge sys_clk);
    en_m = en;
    strap_n <= s;
    rst_n <= 0;
    strap_on <= 1;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    repeat (3) @(posedge sys_clk);
    strap_on <= 0;
    repeat (2) @(negedge sys_clk);
    chk(cfg, ~strap_n);
    chk(33'(core_busy), 33'h0);
  endtask : do_reset
  task automatic dev_txn(input logic m);
    sap_addr_t e;
    logic [4:0] t;
    e = sap_addr_t'({$urandom, $urandom});
    e[MASK_BIT-ADDR_LO] = 1'b1;  // Bit set, so masking shows
    t = 5'($urandom);
    @(posedge sys_clk);
    addr20_mask_in <= m;
    repeat (4) @(posedge sys_clk);
    core_addr <= e;
    core_type <= t;
    core_req <= 1;
    if (m) e[MASK_BIT-ADDR_LO] = 1'b0;
    q.push_back(e);
    wait_st();
    chk(~bus.addr_bus, e);
    chk(lookup_addr, e);
    chk(33'(core_busy), 33'h1);
    chk({28'h0, bus.request_type_n}, {28'h0, ~t});
    chk({32'h0, bus.request_parity_n}, {32'h0, ~^t});
    @(posedge sys_clk);
    core_req <= 0;
    repeat (3) @(negedge sys_clk);
    chk(33'(new_txn), 33'h1);
    chk(snoop_addr, q.pop_front());
  endtask : dev_txn
  task automatic agt_txn(input logic [1:0] f);
    sap_addr_t a;
    logic b;
    a = sap_addr_t'({$urandom, $urandom});
    b = (f != 0);
    @(posedge sys_clk);
    issue_addr <= a;
    issue_req <= 5'($urandom);
    issue_par_flip <= f;
    issue <= 1;
    wait_st();
    chk(bus.addr_bus, a);
    chk(33'(busy), 33'h1);
    @(posedge sys_clk);
    issue <= 0;
    repeat (3) @(negedge sys_clk);
    chk(33'(par_err), 33'(b));
    chk(snoop_addr, ~a);
    chk(33'(busy), 33'h0);
    chk(33'(bus.addr_parity_err_n), 33'(!(b && en_m[1])));
    repeat (3) @(negedge sys_clk);
    chk(33'(err_seen), 33'(b && en_m[1]));
  endtask : agt_txn
  // Error pulse from a third party, then check the abort
  task automatic abort_t();
    @(posedge sys_clk);
    addr_parity_err_n_n <= 0;
    @(posedge sys_clk);
    addr_parity_err_n_n <= 1;
    repeat (3) @(negedge sys_clk);
    chk(33'(txn_abort), 33'(en_m[0]));
  endtask : abort_t
  initial begin
    void'($urandom(14836));
    for (int p = 0; p < 2; p++) begin
      do_reset(p ? 2'h0 : 2'h3);
      dev_txn(1'b0);
      dev_txn(1'b1);
      for (int f = 0; f < 4; f++) agt_txn(2'(f));
      abort_t();
      chk(cfg, ~strap_n);
      $display("test %0d done", p);
    end
    final_report();
  end
endmodule : sysbus_address_phase_tb_top
`default_nettype wire
